//--- rtl/rwp_map.svh
// Register offsets, field positions and reset values of the write protection bank
`ifndef RWP_MAP_SVH
`define RWP_MAP_SVH

`define RWP_ADDR_OPEN_WINDOW 8'h82
`define RWP_ADDR_SERVICE_KEY 8'h83
`define RWP_ADDR_LOCK_FIRST 8'hf0
`define RWP_ADDR_LOCK_SECOND 8'hf1
`define RWP_ADDR_TARGET 8'hf9

`define RWP_RST_SERVICE_KEY 8'h00
`define RWP_RST_LOCK 8'h00
`define RWP_RST_OPEN_WINDOW 8'h00
`define RWP_RD_UNMAPPED 8'h00

`define RWP_LOCK_MASK 8'h7f
`define RWP_LOCK_WORKING_GROUP 6
`define RWP_LOCK_SLEEP_SEQUENCE_GROUP 5
`define RWP_LOCK_POWER_SEQUENCE_GROUP 4
`define RWP_LOCK_SLOT_CONFIG_GROUP 3
`define RWP_LOCK_WATCHDOG_GROUP 2
`define RWP_LOCK_CLOCK_GROUP 1
`define RWP_LOCK_CONTROL_GROUP 0
`define RWP_NUM_GROUPS 7

`define RWP_WIN_STEP2_CODE 8'h20
`define RWP_WIN_STEP4_CODE 8'h40
`define RWP_WIN_BASE1_MS 10'd1
`define RWP_WIN_BASE2_MS 10'd34
`define RWP_WIN_BASE4_MS 10'd100

`endif

//--- rtl/rwp_pkg.sv
// Types shared by the write protection bank
package rwp_pkg;
  typedef enum logic [2:0] {
    RWP_IDLE,
    RWP_ADDR,
    RWP_PTR,
    RWP_WDATA,
    RWP_ACK,
    RWP_RDATA,
    RWP_MACK
  } rwp_state_t;
endpackage : rwp_pkg

//--- rtl/rwp_window_decode.sv
// Window code to duration in milliseconds
`timescale 1ns/1ps
`include "rwp_map.svh"
module rwp_window_decode import rwp_pkg::*; (
  input wire logic [7:0] code,
  output logic [9:0] duration_ms
);
  logic [9:0] code_w;
  assign code_w = {2'b00, code};

  always_comb begin
    if (code < `RWP_WIN_STEP2_CODE) begin
      duration_ms = `RWP_WIN_BASE1_MS + code_w;
    end else if (code < `RWP_WIN_STEP4_CODE) begin
      duration_ms = `RWP_WIN_BASE2_MS + ((code_w - {2'b00, `RWP_WIN_STEP2_CODE}) << 1);
    end else begin
      duration_ms = `RWP_WIN_BASE4_MS + ((code_w - {2'b00, `RWP_WIN_STEP4_CODE}) << 2);
    end
  end
endmodule : rwp_window_decode

//--- rtl/rwp_top.sv
// Watchdog window, service key and group lock registers behind a two-wire target port
`timescale 1ns/1ps
`include "rwp_map.svh"
module rwp_top import rwp_pkg::*; (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [7:0] stored_open_window,
  input wire logic [6:0] stored_target_address,
  input wire logic [7:0] watchdog_closed_window,
  input wire logic selftest_exit_pulse,
  input wire logic selftest_on_shutdown,
  output logic [7:0] watchdog_open_window,
  output logic [7:0] watchdog_service_key,
  output logic service_key_write,
  output logic [6:0] group_locked,
  output logic [10:0] watchdog_period_ms
);
  // ----------------------------------------------------------------
  // Pin synchronisers and bus conditions
  // ----------------------------------------------------------------
  logic scl_m_r, scl_s_r, scl_d_r;
  logic sda_m_r, sda_s_r, sda_d_r;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  assign scl_rise = scl_s_r & ~scl_d_r;
  assign scl_fall = ~scl_s_r & scl_d_r;
  assign bus_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign bus_stop = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  // ----------------------------------------------------------------
  // Stored values loaded once after reset release
  // ----------------------------------------------------------------
  logic load_pend_r;
  logic [6:0] target_addr_r;
  logic [7:0] open_window_r;
  logic [7:0] service_key_r;
  logic [7:0] lock_first_r;
  logic [7:0] lock_second_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      load_pend_r <= 1'b1;
    end else begin
      load_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      target_addr_r <= 7'h00;
    end else if (load_pend_r) begin
      target_addr_r <= stored_target_address;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    case (a)
      `RWP_ADDR_OPEN_WINDOW: rd_byte = open_window_r;
      `RWP_ADDR_SERVICE_KEY: rd_byte = service_key_r;
      `RWP_ADDR_LOCK_FIRST: rd_byte = lock_first_r;
      `RWP_ADDR_LOCK_SECOND: rd_byte = lock_second_r;
      `RWP_ADDR_TARGET: rd_byte = {1'b0, target_addr_r};
      default: rd_byte = `RWP_RD_UNMAPPED;
    endcase
  endfunction : rd_byte

  // ----------------------------------------------------------------
  // Target port state machine
  // ----------------------------------------------------------------
  rwp_state_t st_r, after_ack_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] ptr_r;
  logic oe_r;
  logic wr_stb_r;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic [7:0] rd_now;

  assign rd_now = rd_byte(ptr_r);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= RWP_IDLE;
      after_ack_r <= RWP_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      oe_r <= 1'b0;
      wr_stb_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_stb_r <= 1'b0;
      if (bus_start) begin
        st_r <= RWP_ADDR;
        cnt_r <= 4'h0;
        oe_r <= 1'b0;
      end else if (bus_stop) begin
        st_r <= RWP_IDLE;
        oe_r <= 1'b0;
      end else begin
        case (st_r)
          RWP_ADDR, RWP_PTR, RWP_WDATA: begin
            if (scl_rise && cnt_r < 4'h8) begin
              sh_r <= {sh_r[6:0], sda_s_r};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == 4'h8) begin
              cnt_r <= 4'h0;
              if (st_r == RWP_ADDR) begin
                if (sh_r[7:1] == target_addr_r) begin
                  oe_r <= 1'b1;
                  st_r <= RWP_ACK;
                  after_ack_r <= sh_r[0] ? RWP_RDATA : RWP_PTR;
                end else begin
                  st_r <= RWP_IDLE;
                end
              end else if (st_r == RWP_PTR) begin
                ptr_r <= sh_r;
                oe_r <= 1'b1;
                st_r <= RWP_ACK;
                after_ack_r <= RWP_WDATA;
              end else begin
                wr_stb_r <= 1'b1;
                wr_addr_r <= ptr_r;
                wr_data_r <= sh_r;
                ptr_r <= ptr_r + 8'h01;
                oe_r <= 1'b1;
                st_r <= RWP_ACK;
                after_ack_r <= RWP_WDATA;
              end
            end
          end
          RWP_ACK: begin
            if (scl_fall) begin
              cnt_r <= 4'h0;
              st_r <= after_ack_r;
              if (after_ack_r == RWP_RDATA) begin
                sh_r <= rd_now;
                oe_r <= ~rd_now[7];
                ptr_r <= ptr_r + 8'h01;
              end else begin
                oe_r <= 1'b0;
              end
            end
          end
          RWP_RDATA: begin
            if (scl_rise) begin
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall) begin
              if (cnt_r == 4'h8) begin
                oe_r <= 1'b0;
                st_r <= RWP_MACK;
              end else begin
                sh_r <= {sh_r[6:0], 1'b0};
                oe_r <= ~sh_r[6];
              end
            end
          end
          RWP_MACK: begin
            if (scl_rise) begin
              if (sda_s_r) begin
                st_r <= RWP_IDLE;
              end else begin
                st_r <= RWP_ACK;
                after_ack_r <= RWP_RDATA;
              end
            end
          end
          RWP_IDLE: begin
            oe_r <= 1'b0;
          end
          default: begin
            st_r <= RWP_IDLE;
            oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] lock_both;
  logic wdt_locked;
  logic lock_clear;

  assign lock_both = lock_first_r & lock_second_r;
  assign wdt_locked = lock_both[`RWP_LOCK_WATCHDOG_GROUP];
  assign lock_clear = selftest_exit_pulse & selftest_on_shutdown;

  // Stored load, then writable only while unlocked
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      open_window_r <= `RWP_RST_OPEN_WINDOW;
    end else if (load_pend_r) begin
      open_window_r <= stored_open_window;
    end else if (wr_stb_r && wr_addr_r == `RWP_ADDR_OPEN_WINDOW && !wdt_locked) begin
      open_window_r <= wr_data_r;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      service_key_r <= `RWP_RST_SERVICE_KEY;
      service_key_write <= 1'b0;
    end else begin
      service_key_write <= wr_stb_r && wr_addr_r == `RWP_ADDR_SERVICE_KEY;
      if (wr_stb_r && wr_addr_r == `RWP_ADDR_SERVICE_KEY) begin
        service_key_r <= wr_data_r;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lock_first_r <= `RWP_RST_LOCK;
      lock_second_r <= `RWP_RST_LOCK;
    end else begin
      // Reserved bit masked; a host set in the clear cycle wins
      lock_first_r <= (lock_clear ? `RWP_RST_LOCK : lock_first_r) |
        ((wr_stb_r && wr_addr_r == `RWP_ADDR_LOCK_FIRST) ? (wr_data_r & `RWP_LOCK_MASK) : 8'h00);
      lock_second_r <= (lock_clear ? `RWP_RST_LOCK : lock_second_r) |
        ((wr_stb_r && wr_addr_r == `RWP_ADDR_LOCK_SECOND) ? (wr_data_r & `RWP_LOCK_MASK) : 8'h00);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [9:0] open_ms, closed_ms;

  rwp_window_decode u_open_dec (
    .code(open_window_r),
    .duration_ms(open_ms)
  );

  rwp_window_decode u_closed_dec (
    .code(watchdog_closed_window),
    .duration_ms(closed_ms)
  );

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_period_ms <= 11'h000;
      group_locked <= 7'h00;
      watchdog_open_window <= `RWP_RST_OPEN_WINDOW;
      watchdog_service_key <= `RWP_RST_SERVICE_KEY;
    end else begin
      watchdog_period_ms <= {1'b0, closed_ms} + {1'b0, open_ms};
      group_locked <= lock_both[6:0];
      watchdog_open_window <= open_window_r;
      watchdog_service_key <= service_key_r;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = oe_r;
endmodule : rwp_top

//--- verif/rwp_top_monitor.sv
// Port checks for the write protection bank
`timescale 1ns/1ps
module rwp_top_monitor (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic selftest_exit_pulse,
  input wire logic selftest_on_shutdown,
  input wire logic [7:0] watchdog_closed_window,
  input wire logic [7:0] watchdog_open_window,
  input wire logic [7:0] watchdog_service_key,
  input wire logic service_key_write,
  input wire logic [6:0] group_locked,
  input wire logic [10:0] watchdog_period_ms
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [7:0] since_wr_r;
  function automatic logic [10:0] win_ms(input logic [7:0] c);
    if (c < 8'h20) return 11'(c) + 11'd1;
    if (c < 8'h40) return 11'd34 + 11'(c - 8'h20) * 11'd2;
    return 11'd100 + 11'(c - 8'h40) * 11'd4;
  endfunction : win_ms
  // Cycles since the last key write
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) since_wr_r <= 8'hff;
    else if (service_key_write) since_wr_r <= 8'h00;
    else if (since_wr_r != 8'hff) since_wr_r <= since_wr_r + 8'h01;
  end
  sequence s_quiet;
    ($stable(watchdog_open_window) && $stable(watchdog_closed_window)) [*4];
  endsequence
  property p_period;
    s_quiet |-> watchdog_period_ms ==
      win_ms(watchdog_open_window) + win_ms(watchdog_closed_window);
  endproperty
  a_period: assert property (p_period) else $error("period mismatch");
  property p_no_clear;
    |(~group_locked & $past(group_locked)) |-> ($past(selftest_exit_pulse) ||
      $past(selftest_exit_pulse, 2) || $past(selftest_exit_pulse, 3));
  endproperty
  a_no_clear: assert property (p_no_clear) else $error("lock bit cleared");
  property p_clear;
    selftest_exit_pulse && selftest_on_shutdown |-> ##[1:3] group_locked == 7'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("locks not cleared");
  property p_keep;
    selftest_exit_pulse && !selftest_on_shutdown |=> $stable(group_locked) [*3];
  endproperty
  a_keep: assert property (p_keep) else $error("locks cleared without option");
  property p_open_lock;
    group_locked[2] && $past(group_locked[2]) |-> $stable(watchdog_open_window);
  endproperty
  a_open_lock: assert property (p_open_lock) else $error("locked window changed");
  property p_open_src;
    $changed(watchdog_open_window) |-> !$past(group_locked[2], 2);
  endproperty
  a_open_src: assert property (p_open_src) else $error("window written while locked");
  property p_pulse;
    service_key_write |=> !service_key_write;
  endproperty
  a_pulse: assert property (p_pulse) else $error("key pulse too long");
  property p_key;
    $changed(watchdog_service_key) |-> (since_wr_r < 8'd40) or (##[0:40] service_key_write);
  endproperty
  a_key: assert property (p_key) else $error("key changed without write");
endmodule : rwp_top_monitor

bind rwp_top rwp_top_monitor mon (.mclk(mclk), .reset_n(reset_n),
  .selftest_exit_pulse(selftest_exit_pulse), .selftest_on_shutdown(selftest_on_shutdown),
  .watchdog_closed_window(watchdog_closed_window), .watchdog_open_window(watchdog_open_window),
  .watchdog_service_key(watchdog_service_key), .service_key_write(service_key_write),
  .group_locked(group_locked), .watchdog_period_ms(watchdog_period_ms));

//--- verif/rwp_top_tb.sv
// Self-checking bench for the write protection bank
`timescale 1ns/1ps
module rwp_top_tb import rwp_pkg::*;;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic scl = 1'b1;
  logic sda_m = 1'b1;
  logic st_pulse = 1'b0;
  logic st_opt = 1'b0;
  logic [7:0] cw = 8'h01;
  logic sda_oe;
  logic skw;
  logic [7:0] owin;
  logic [7:0] key;
  logic [6:0] glock;
  logic [10:0] per;
  logic sda_drv;
  wire sda = sda_m & ~(sda_oe & ~sda_drv);
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  localparam logic [6:0] ta = 7'h2a;
  localparam logic [7:0] sow = 8'h25;
  logic [7:0] codes [8] = '{8'h00, 8'h1f, 8'h20, 8'h3f, 8'h40, 8'hff, 8'h04, 8'h24};
  logic [10:0] msv [8] = '{11'd1, 11'd32, 11'd34, 11'd96, 11'd100, 11'd864, 11'd5, 11'd42};
  rwp_top dut (.mclk(mclk), .reset_n(reset_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_drv),
    .sda_oe(sda_oe), .stored_open_window(sow), .stored_target_address(ta),
    .watchdog_closed_window(cw), .selftest_exit_pulse(st_pulse),
    .selftest_on_shutdown(st_opt), .watchdog_open_window(owin), .watchdog_service_key(key),
    .service_key_write(skw), .group_locked(glock), .watchdog_period_ms(per));
  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic half();
    repeat (8) @(posedge mclk);
  endtask : half
  task automatic xbit(input logic b, output logic r);
    half();
    sda_m <= b;
    half();
    scl <= 1'b1;
    half();
    @(negedge mclk) r = sda;
    @(posedge mclk) scl <= 1'b0;
  endtask : xbit
  task automatic xbyte(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) xbit(d[i], q[i]);
  endtask : xbyte
  task automatic start();
    half();
    sda_m <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_m <= 1'b0;
    half();
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    half();
    sda_m <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_m <= 1'b1;
    half();
  endtask : stop
  task automatic sel(input logic r, input logic [7:0] a);
    logic [8:0] q;
    start();
    xbyte({ta, r, 1'b1}, q);
    chk("addr ack", 11'h0, 11'(q[0]));
    if (!r) xbyte({a, 1'b1}, q);
  endtask : sel
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [8:0] q;
    sel(1'b0, a);
    xbyte({d, 1'b1}, q);
    chk($sformatf("ack %h", a), 11'h0, 11'(q[0]));
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [8:0] q;
    sel(1'b0, a);
    sel(1'b1, a);
    xbyte(9'h1ff, q);
    stop();
    chk($sformatf("reg %h", a), 11'(e), 11'(q[8:1]));
  endtask : rd
  task automatic pulse();
    st_pulse <= 1'b1;
    @(posedge mclk);
    st_pulse <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : pulse
  task automatic power_up();
    reset_n <= 1'b0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (10) @(posedge mclk);
  endtask : power_up
  // ----------------
  // Tests
  // ----------------
  initial begin
    logic [8:0] q;
    power_up();
    rd(8'h83, 8'h00);
    rd(8'hf0, 8'h00);
    rd(8'hf1, 8'h00);
    rd(8'h82, sow);
    rd(8'hf9, {1'b0, ta});
    start();
    xbyte({~ta, 1'b0, 1'b1}, q);
    chk("foreign addr ack", 11'h1, 11'(q[0]));
    stop();
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      cw <= codes[7 - i];
      wr(8'h82, codes[i]);
      repeat (8) @(posedge mclk);
      chk("open window", 11'(codes[i]), 11'(owin));
      chk("period", msv[i] + msv[7 - i], per);
    end
    rd(8'h82, 8'h24);
    wr(8'h83, 8'h5a);
    chk("key", 11'h5a, 11'(key));
    $display("test window and key done");
    wr(8'hf0, 8'h04);
    chk("lock one", 11'h0, 11'(glock));
    wr(8'h82, 8'h11);
    wr(8'hf1, 8'h04);
    chk("lock both", 11'h4, 11'(glock));
    wr(8'h82, 8'h77);
    rd(8'h82, 8'h11);
    wr(8'hf0, 8'h80);
    rd(8'hf0, 8'h04);
    wr(8'hf9, 8'h00);
    rd(8'hf9, {1'b0, ta});
    wr(8'hf0, 8'h7f);
    wr(8'hf1, 8'h7b);
    chk("lock all", 11'h7f, 11'(glock));
    sel(1'b0, 8'hf0);
    sel(1'b1, 8'hf0);
    xbyte(9'h1fe, q);
    chk("burst first", 11'h7f, 11'(q[8:1]));
    xbyte(9'h1ff, q);
    stop();
    chk("burst second", 11'h7f, 11'(q[8:1]));
    $display("test locks done");
    pulse();
    chk("no option", 11'h7f, 11'(glock));
    st_opt <= 1'b1;
    pulse();
    chk("self-test clear", 11'h0, 11'(glock));
    rd(8'hf1, 8'h00);
    $display("test self-test done");
    wr(8'hf0, 8'h02);
    wr(8'hf1, 8'h02);
    chk("relock", 11'h2, 11'(glock));
    power_up();
    chk("power cycle", 11'h0, 11'(glock));
    rd(8'hf0, 8'h00);
    $display("test power cycle done");
    close_out();
  end
endmodule : rwp_top_tb
